// ### pkg/cursor_mode_if.sv
// Mode code and pixel byte to the decoder, decoded format back
`timescale 1ns/1ps
interface cursor_mode_if;
   logic [cursor_pkg::MODE_W-1:0] mode;
   logic [7:0] alpha;
   cursor_pkg::cursor_fmt_t fmt;
   logic [3:0] size_log2;
   logic bpp32;
   logic valid;
   cursor_pkg::pixel_op_t pix_op;

   modport decoder (input mode, input alpha, output fmt, output size_log2, output bpp32, output valid,
      output pix_op);
   modport user (output mode, output alpha, input fmt, input size_log2, input bpp32, input valid,
      input pix_op);
endinterface : cursor_mode_if

// ### pkg/cursor_pkg.sv
// Constants, field layouts and types for the cursor plane configuration block
package cursor_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int PHYS_W = 39;
   localparam int MODE_W = 4;
   localparam int MAG_W = 12;
   localparam int POS_W = 13;
   localparam int ROT_OFS_W = 19;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 20'h70080;
   localparam logic [ADDR_W-1:0] BASE_OFFSET = 20'h70084;
   localparam logic [ADDR_W-1:0] POS_OFFSET = 20'h70088;
   localparam logic [ADDR_W-1:0] POPUP_OFFSET = 20'h7008C;

   // Reset values
   localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] BASE_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] POS_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] POPUP_RESET = 32'h00000000;

   // Implemented bits; all others store nothing and read zero
   localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h08008027;
   localparam logic [DATA_W-1:0] BASE_WMASK = 32'hFFFFF000;
   localparam logic [DATA_W-1:0] POS_WMASK = 32'h8FFF8FFF;
   localparam logic [DATA_W-1:0] POPUP_WMASK = 32'hFFFFF07F;

   // Field positions
   localparam int CTRL_POPUP_BIT = 27;
   localparam int CTRL_ROT_BIT = 15;
   localparam int CTRL_MODE_HI_BIT = 5;
   localparam int CTRL_MODE_LO_MSB = 2;
   localparam int BASE_LSB = 12;
   localparam int POPUP_HI_MSB = 6;
   localparam int POS_Y_SIGN_BIT = 31;
   localparam int POS_Y_MAG_LSB = 16;
   localparam int POS_X_SIGN_BIT = 15;
   localparam int POS_X_MAG_LSB = 0;

   // Mode codes as {high bit, low three bits}
   localparam logic [MODE_W-1:0] MODE_DISABLED = 4'h0;
   localparam logic [MODE_W-1:0] MODE_AINV_128 = 4'h2;
   localparam logic [MODE_W-1:0] MODE_AINV_256 = 4'h3;
   localparam logic [MODE_W-1:0] MODE_IDX3_64 = 4'h4;
   localparam logic [MODE_W-1:0] MODE_ANDXOR2_64 = 4'h5;
   localparam logic [MODE_W-1:0] MODE_IDX4_64 = 4'h6;
   localparam logic [MODE_W-1:0] MODE_AINV_64 = 4'h7;
   localparam logic [MODE_W-1:0] MODE_ARGB_128 = 4'hA;
   localparam logic [MODE_W-1:0] MODE_ARGB_256 = 4'hB;
   localparam logic [MODE_W-1:0] MODE_AXOR_64 = 4'hC;
   localparam logic [MODE_W-1:0] MODE_AXOR_128 = 4'hD;
   localparam logic [MODE_W-1:0] MODE_AXOR_256 = 4'hE;
   localparam logic [MODE_W-1:0] MODE_ARGB_64 = 4'hF;

   // Cursor edge as log2 of pixels
   localparam logic [3:0] SIZE_LOG2_NONE = 4'h0;
   localparam logic [3:0] SIZE_LOG2_64 = 4'h6;
   localparam logic [3:0] SIZE_LOG2_128 = 4'h7;
   localparam logic [3:0] SIZE_LOG2_256 = 4'h8;
   localparam logic [4:0] BPP32_BYTES_LOG2 = 5'h02;
   localparam logic [ROT_OFS_W-1:0] LAST_PX_BYTES = 19'h00004;

   localparam logic [7:0] ALPHA_ONES = 8'hFF;
   localparam logic [7:0] ALPHA_ZEROS = 8'h00;

   typedef enum logic [2:0] {
      FMT_NONE = 3'h0,
      FMT_IDX3 = 3'h1,
      FMT_ANDXOR2 = 3'h2,
      FMT_IDX4 = 3'h3,
      FMT_AND_INVERT = 3'h4,
      FMT_AND_XOR = 3'h5,
      FMT_ARGB = 3'h6
   } cursor_fmt_t;

   typedef enum logic [2:0] {
      PIX_TRANSPARENT = 3'h0,
      PIX_OPAQUE = 3'h1,
      PIX_INVERT = 3'h2,
      PIX_XOR = 3'h3,
      PIX_ALPHA = 3'h4,
      PIX_INDEXED = 3'h5
   } pixel_op_t;

   typedef enum logic [1:0] {
      FETCH_IDLE = 2'b00,
      FETCH_RUN = 2'b01,
      FETCH_DRAIN = 2'b11
   } fetch_state_t;
endpackage : cursor_pkg

// ### rtl/cursor_mode_decode.sv
// Cursor mode code decoder and per-pixel blend classifier
`timescale 1ns/1ps
module cursor_mode_decode (
   cursor_mode_if.decoder dec
);
   always_comb begin
      dec.fmt = cursor_pkg::FMT_NONE;
      dec.size_log2 = cursor_pkg::SIZE_LOG2_NONE;
      dec.bpp32 = 1'b0;
      dec.valid = 1'b1;
      case (dec.mode)
         cursor_pkg::MODE_IDX3_64: begin
            dec.fmt = cursor_pkg::FMT_IDX3;
            dec.size_log2 = cursor_pkg::SIZE_LOG2_64;
         end
         cursor_pkg::MODE_ANDXOR2_64: begin
            dec.fmt = cursor_pkg::FMT_ANDXOR2;
            dec.size_log2 = cursor_pkg::SIZE_LOG2_64;
         end
         cursor_pkg::MODE_IDX4_64: begin
            dec.fmt = cursor_pkg::FMT_IDX4;
            dec.size_log2 = cursor_pkg::SIZE_LOG2_64;
         end
         cursor_pkg::MODE_AINV_64, cursor_pkg::MODE_AINV_128, cursor_pkg::MODE_AINV_256: begin
            dec.fmt = cursor_pkg::FMT_AND_INVERT;
            dec.bpp32 = 1'b1;
            dec.size_log2 = (dec.mode == cursor_pkg::MODE_AINV_64) ? cursor_pkg::SIZE_LOG2_64 :
               (dec.mode == cursor_pkg::MODE_AINV_128) ? cursor_pkg::SIZE_LOG2_128 : cursor_pkg::SIZE_LOG2_256;
         end
         cursor_pkg::MODE_AXOR_64, cursor_pkg::MODE_AXOR_128, cursor_pkg::MODE_AXOR_256: begin
            dec.fmt = cursor_pkg::FMT_AND_XOR;
            dec.bpp32 = 1'b1;
            dec.size_log2 = (dec.mode == cursor_pkg::MODE_AXOR_64) ? cursor_pkg::SIZE_LOG2_64 :
               (dec.mode == cursor_pkg::MODE_AXOR_128) ? cursor_pkg::SIZE_LOG2_128 : cursor_pkg::SIZE_LOG2_256;
         end
         cursor_pkg::MODE_ARGB_64, cursor_pkg::MODE_ARGB_128, cursor_pkg::MODE_ARGB_256: begin
            dec.fmt = cursor_pkg::FMT_ARGB;
            dec.bpp32 = 1'b1;
            dec.size_log2 = (dec.mode == cursor_pkg::MODE_ARGB_64) ? cursor_pkg::SIZE_LOG2_64 :
               (dec.mode == cursor_pkg::MODE_ARGB_128) ? cursor_pkg::SIZE_LOG2_128 : cursor_pkg::SIZE_LOG2_256;
         end
         default: begin
            // Disabled and reserved codes alike
            dec.valid = 1'b0;
         end
      endcase
   end

   always_comb begin
      dec.pix_op = cursor_pkg::PIX_TRANSPARENT;
      case (dec.fmt)
         cursor_pkg::FMT_IDX3, cursor_pkg::FMT_ANDXOR2, cursor_pkg::FMT_IDX4: begin
            dec.pix_op = cursor_pkg::PIX_INDEXED;
         end
         cursor_pkg::FMT_AND_INVERT: begin
            if (dec.alpha == cursor_pkg::ALPHA_ONES) begin
               dec.pix_op = cursor_pkg::PIX_OPAQUE;
            end else if (dec.alpha == cursor_pkg::ALPHA_ZEROS) begin
               dec.pix_op = cursor_pkg::PIX_TRANSPARENT;
            end else begin
               dec.pix_op = cursor_pkg::PIX_INVERT;
            end
         end
         cursor_pkg::FMT_AND_XOR: begin
            if (dec.alpha == cursor_pkg::ALPHA_ONES) begin
               dec.pix_op = cursor_pkg::PIX_OPAQUE;
            end else if (dec.alpha == cursor_pkg::ALPHA_ZEROS) begin
               dec.pix_op = cursor_pkg::PIX_TRANSPARENT;
            end else begin
               dec.pix_op = cursor_pkg::PIX_XOR;
            end
         end
         cursor_pkg::FMT_ARGB: begin
            dec.pix_op = cursor_pkg::PIX_ALPHA;
         end
         default: begin
            dec.pix_op = cursor_pkg::PIX_TRANSPARENT;
         end
      endcase
   end
endmodule : cursor_mode_decode

// ### rtl/hw_cursor_plane_config.sv
// Cursor plane configuration registers with double buffering and fetch control
`timescale 1ns/1ps
module hw_cursor_plane_config (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic mmio_wr_en,
   input wire logic mmio_rd_en,
   input wire logic [cursor_pkg::ADDR_W-1:0] mmio_addr,
   input wire logic [cursor_pkg::DATA_W-1:0] mmio_wdata,
   output logic [cursor_pkg::DATA_W-1:0] mmio_rdata,
   output logic mmio_rd_valid,
   input wire logic vblank_start,
   input wire logic pipe_enabled,
   input wire logic pipe_cursor_disable,
   input wire logic [7:0] pixel_alpha,
   output cursor_pkg::pixel_op_t pixel_op,
   output cursor_pkg::cursor_fmt_t cursor_format,
   output logic [3:0] cursor_size_log2,
   output logic cursor_visible,
   output logic fetch_enable,
   output logic addr_is_physical,
   output logic [cursor_pkg::PHYS_W-1:0] fetch_base,
   output logic [cursor_pkg::PHYS_W-1:0] fetch_start,
   output logic rotate_180,
   output logic pos_from_end,
   output logic [cursor_pkg::POS_W-1:0] pos_x,
   output logic [cursor_pkg::POS_W-1:0] pos_y
);
   logic [cursor_pkg::DATA_W-1:0] pend_ctrl;
   logic [cursor_pkg::DATA_W-1:0] pend_base;
   logic [cursor_pkg::DATA_W-1:0] pend_pos;
   logic [cursor_pkg::DATA_W-1:0] pend_popup;
   logic [cursor_pkg::DATA_W-1:0] act_ctrl;
   logic [cursor_pkg::DATA_W-1:0] act_base;
   logic [cursor_pkg::DATA_W-1:0] act_pos;
   logic [cursor_pkg::DATA_W-1:0] act_popup;
   logic armed;
   logic wr_ctrl;
   logic wr_base;
   logic wr_pos;
   logic wr_popup;
   logic update_now;
   logic act_popup_en;
   logic eff_valid;
   logic eff_rot;
   logic [cursor_pkg::PHYS_W-1:0] next_fetch_base;
   logic [cursor_pkg::ROT_OFS_W-1:0] rot_span;
   logic [cursor_pkg::ROT_OFS_W-1:0] rot_ofs;
   logic [4:0] span_shift;
   cursor_pkg::fetch_state_t fetch_state;
   cursor_pkg::fetch_state_t next_fetch_state;

   cursor_mode_if mode_bus ();

   cursor_mode_decode u_decode (
      .dec(mode_bus.decoder)
   );

   // Register decode
   assign wr_ctrl = mmio_wr_en && (mmio_addr == cursor_pkg::CTRL_OFFSET);
   assign wr_base = mmio_wr_en && (mmio_addr == cursor_pkg::BASE_OFFSET);
   assign wr_pos = mmio_wr_en && (mmio_addr == cursor_pkg::POS_OFFSET);
   assign wr_popup = mmio_wr_en && (mmio_addr == cursor_pkg::POPUP_OFFSET);

   // Pending copies, written by software
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pend_ctrl <= cursor_pkg::CTRL_RESET;
         pend_base <= cursor_pkg::BASE_RESET;
         pend_pos <= cursor_pkg::POS_RESET;
         pend_popup <= cursor_pkg::POPUP_RESET;
      end else begin
         if (wr_ctrl) begin
            pend_ctrl <= mmio_wdata & cursor_pkg::CTRL_WMASK;
         end
         if (wr_base) begin
            pend_base <= mmio_wdata & cursor_pkg::BASE_WMASK;
         end
         if (wr_pos) begin
            pend_pos <= mmio_wdata & cursor_pkg::POS_WMASK;
         end
         if (wr_popup) begin
            pend_popup <= mmio_wdata & cursor_pkg::POPUP_WMASK;
         end
      end
   end

   // Arming; a base write in the update cycle keeps it armed
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         armed <= 1'b0;
      end else if (wr_base || wr_popup) begin
         armed <= 1'b1;
      end else if (update_now) begin
         armed <= 1'b0;
      end
   end

   assign mode_bus.mode = {act_ctrl[cursor_pkg::CTRL_MODE_HI_BIT], act_ctrl[cursor_pkg::CTRL_MODE_LO_MSB:0]};
   assign mode_bus.alpha = pixel_alpha;
   assign act_popup_en = act_ctrl[cursor_pkg::CTRL_POPUP_BIT];

   // Update point: vblank start, pipe off, or cursor currently off
   assign update_now = armed && (vblank_start || !pipe_enabled || !mode_bus.valid);

   // Active copies, moved together
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         act_ctrl <= cursor_pkg::CTRL_RESET;
         act_base <= cursor_pkg::BASE_RESET;
         act_pos <= cursor_pkg::POS_RESET;
         act_popup <= cursor_pkg::POPUP_RESET;
      end else if (update_now) begin
         act_ctrl <= pend_ctrl;
         act_base <= pend_base;
         act_pos <= pend_pos;
         act_popup <= pend_popup;
      end
   end

   // 32bpp formats cannot run as popup; rotation applies to 32bpp only
   assign eff_valid = mode_bus.valid && !(act_popup_en && mode_bus.bpp32);
   assign eff_rot = act_ctrl[cursor_pkg::CTRL_ROT_BIT] && mode_bus.bpp32;

   // Base address selection
   always_comb begin
      if (act_popup_en) begin
         next_fetch_base = {act_popup[cursor_pkg::POPUP_HI_MSB:0], act_popup[31:cursor_pkg::BASE_LSB],
            {cursor_pkg::BASE_LSB{1'b0}}};
      end else begin
         next_fetch_base = {{(cursor_pkg::PHYS_W - 32){1'b0}}, act_base[31:cursor_pkg::BASE_LSB],
            {cursor_pkg::BASE_LSB{1'b0}}};
      end
   end

   // Offset to last pixel of last line for rotated 32bpp surfaces
   assign span_shift = {mode_bus.size_log2, 1'b0} + cursor_pkg::BPP32_BYTES_LOG2;
   assign rot_span = {{(cursor_pkg::ROT_OFS_W - 1){1'b0}}, 1'b1} << span_shift;
   assign rot_ofs = eff_rot ? (rot_span - cursor_pkg::LAST_PX_BYTES) : '0;

   // Fetch sequencer
   always_comb begin
      next_fetch_state = fetch_state;
      case (fetch_state)
         cursor_pkg::FETCH_IDLE: begin
            if (eff_valid && pipe_enabled) begin
               next_fetch_state = cursor_pkg::FETCH_RUN;
            end
         end
         cursor_pkg::FETCH_RUN: begin
            if (!pipe_enabled) begin
               next_fetch_state = cursor_pkg::FETCH_IDLE;
            end else if (!eff_valid) begin
               next_fetch_state = cursor_pkg::FETCH_DRAIN;
            end
         end
         cursor_pkg::FETCH_DRAIN: begin
            if (!pipe_enabled) begin
               next_fetch_state = cursor_pkg::FETCH_IDLE;
            end else if (eff_valid) begin
               next_fetch_state = cursor_pkg::FETCH_RUN;
            end else if (vblank_start) begin
               next_fetch_state = cursor_pkg::FETCH_IDLE;
            end
         end
         default: begin
            next_fetch_state = cursor_pkg::FETCH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fetch_state <= cursor_pkg::FETCH_IDLE;
      end else begin
         fetch_state <= next_fetch_state;
      end
   end

   assign fetch_enable = (fetch_state != cursor_pkg::FETCH_IDLE);

   // Registered outputs to the blender and fetch unit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cursor_format <= cursor_pkg::FMT_NONE;
         cursor_size_log2 <= cursor_pkg::SIZE_LOG2_NONE;
         cursor_visible <= 1'b0;
         addr_is_physical <= 1'b0;
         fetch_base <= '0;
         fetch_start <= '0;
         rotate_180 <= 1'b0;
         pos_from_end <= 1'b0;
         pixel_op <= cursor_pkg::PIX_TRANSPARENT;
      end else begin
         cursor_format <= eff_valid ? mode_bus.fmt : cursor_pkg::FMT_NONE;
         cursor_size_log2 <= eff_valid ? mode_bus.size_log2 : cursor_pkg::SIZE_LOG2_NONE;
         cursor_visible <= eff_valid && !pipe_cursor_disable;
         addr_is_physical <= act_popup_en;
         fetch_base <= next_fetch_base;
         fetch_start <= next_fetch_base + {{(cursor_pkg::PHYS_W - cursor_pkg::ROT_OFS_W){1'b0}}, rot_ofs};
         rotate_180 <= eff_rot;
         pos_from_end <= eff_rot;
         pixel_op <= (eff_valid && !pipe_cursor_disable) ? mode_bus.pix_op : cursor_pkg::PIX_TRANSPARENT;
      end
   end

   // Sign-magnitude position to two's complement
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pos_x <= '0;
         pos_y <= '0;
      end else begin
         pos_x <= act_pos[cursor_pkg::POS_X_SIGN_BIT] ?
            -{1'b0, act_pos[cursor_pkg::POS_X_MAG_LSB +: cursor_pkg::MAG_W]} :
            {1'b0, act_pos[cursor_pkg::POS_X_MAG_LSB +: cursor_pkg::MAG_W]};
         pos_y <= act_pos[cursor_pkg::POS_Y_SIGN_BIT] ?
            -{1'b0, act_pos[cursor_pkg::POS_Y_MAG_LSB +: cursor_pkg::MAG_W]} :
            {1'b0, act_pos[cursor_pkg::POS_Y_MAG_LSB +: cursor_pkg::MAG_W]};
      end
   end

   // Read port returns the software-written copies
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mmio_rdata <= '0;
         mmio_rd_valid <= 1'b0;
      end else begin
         mmio_rd_valid <= mmio_rd_en;
         if (mmio_rd_en) begin
            case (mmio_addr)
               cursor_pkg::CTRL_OFFSET: mmio_rdata <= pend_ctrl;
               cursor_pkg::BASE_OFFSET: mmio_rdata <= pend_base;
               cursor_pkg::POS_OFFSET: mmio_rdata <= pend_pos;
               cursor_pkg::POPUP_OFFSET: mmio_rdata <= pend_popup;
               default: mmio_rdata <= '0;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_disabled_blank;
      (mode_bus.mode == cursor_pkg::MODE_DISABLED) |=> (!cursor_visible && cursor_format == cursor_pkg::FMT_NONE);
   endproperty
   a_disabled_blank: assert property (p_disabled_blank) else $error("disabled mode shows cursor");

   property p_drain_hold;
      (fetch_state == cursor_pkg::FETCH_RUN && !eff_valid && pipe_enabled) |=> fetch_enable;
   endproperty
   a_drain_hold: assert property (p_drain_hold) else $error("fetch stopped before vblank");

   property p_drain_stop;
      (fetch_state == cursor_pkg::FETCH_DRAIN && vblank_start && !eff_valid) |=> !fetch_enable;
   endproperty
   a_drain_stop: assert property (p_drain_stop) else $error("fetch still running after vblank");

   property p_pipe_override;
      (pipe_cursor_disable && !update_now) |=> (!cursor_visible && $stable(act_ctrl));
   endproperty
   a_pipe_override: assert property (p_pipe_override) else $error("pipe cursor disable not obeyed");

   property p_arm_on_base;
      (wr_base || wr_popup) |=> armed;
   endproperty
   a_arm_on_base: assert property (p_arm_on_base) else $error("base write did not arm");

   property p_vblank_update;
      (armed && vblank_start && !wr_base && !wr_popup) |=>
         (!armed && act_base == $past(pend_base) && act_pos == $past(pend_pos));
   endproperty
   a_vblank_update: assert property (p_vblank_update) else $error("armed values not moved at vblank");

   property p_rot_offset;
      (rotate_180 && cursor_size_log2 == cursor_pkg::SIZE_LOG2_64) |-> (fetch_start - fetch_base == 39'h0000003FFC);
   endproperty
   a_rot_offset: assert property (p_rot_offset) else $error("rotated start offset wrong");

   property p_neg_y;
      (act_pos[cursor_pkg::POS_Y_SIGN_BIT] && act_pos[27:16] != 12'h000) |=> pos_y[cursor_pkg::POS_W-1];
   endproperty
   a_neg_y: assert property (p_neg_y) else $error("negative vertical position lost");

   property p_neg_x;
      (act_pos[cursor_pkg::POS_X_SIGN_BIT] && act_pos[11:0] != 12'h000) |=> pos_x[cursor_pkg::POS_W-1];
   endproperty
   a_neg_x: assert property (p_neg_x) else $error("negative horizontal position lost");

   property p_off_update;
      (armed && !mode_bus.valid && !wr_base && !wr_popup) |=> (!armed && act_ctrl == $past(pend_ctrl));
   endproperty
   a_off_update: assert property (p_off_update) else $error("control not updated while cursor off");

   property p_reserved_idle;
      (!mode_bus.valid && !armed && fetch_state == cursor_pkg::FETCH_IDLE) |=> (!fetch_enable ##1 !cursor_visible);
   endproperty
   a_reserved_idle: assert property (p_reserved_idle) else $error("reserved mode fetches");
endmodule : hw_cursor_plane_config

// ### verification/hw_cursor_plane_config_bench.sv
// Self-checking bench for the cursor plane configuration block
`timescale 1ns/1ps
module hw_cursor_plane_config_bench;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic pen = 1'h1;
   logic pcd = 1'h0;
   logic [19:0] addr = 20'h00000;
   logic [31:0] wdata = 32'h00000000;
   logic [7:0] alpha = 8'h00;
   logic [31:0] rdata;
   logic rvalid, vbl, vis, fen, phys, rot, pfe;
   cursor_pkg::pixel_op_t pop;
   cursor_pkg::cursor_fmt_t fmt;
   logic [3:0] sz;
   logic [38:0] fbase, fstart;
   logic [12:0] px, py;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;

   hw_cursor_plane_config DUT (.clk_sys(clk_sys), .resetn(resetn), .mmio_wr_en(wr), .mmio_rd_en(rd),
      .mmio_addr(addr), .mmio_wdata(wdata), .mmio_rdata(rdata), .mmio_rd_valid(rvalid),
      .vblank_start(vbl), .pipe_enabled(pen), .pipe_cursor_disable(pcd), .pixel_alpha(alpha),
      .pixel_op(pop), .cursor_format(fmt), .cursor_size_log2(sz), .cursor_visible(vis),
      .fetch_enable(fen), .addr_is_physical(phys), .fetch_base(fbase), .fetch_start(fstart),
      .rotate_180(rot), .pos_from_end(pfe), .pos_x(px), .pos_y(py));
   pipe_model pipe (.clk_sys(clk_sys), .resetn(resetn), .vblank_start(vbl));

   initial forever #20 clk_sys = ~clk_sys;

   task automatic chk(input logic [38:0] got, input logic [38:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [19:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'h0;
   endtask : wr_reg

   task automatic rd_reg(input logic [19:0] a);
      @(posedge clk_sys);
      rd <= 1'h1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'h0;
      #1;
   endtask : rd_reg

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   task automatic t_regs();
      logic [19:0] offs [4] = '{cursor_pkg::CTRL_OFFSET, cursor_pkg::BASE_OFFSET, cursor_pkg::POS_OFFSET,
         cursor_pkg::POPUP_OFFSET};
      logic [31:0] msk [4] = '{32'h08008027, 32'hFFFFF000, 32'h8FFF8FFF, 32'hFFFFF07F};
      for (int i = 0; i < 4; i++) begin
         rd_reg(offs[i]);
         chk(rdata, 32'h00000000);
         chk(rvalid, 1'h1);
         wr_reg(offs[i], 32'hFFFFFFFF);
         rd_reg(offs[i]);
         chk(rdata, msk[i]);
      end
      rd_reg(20'h70090);
      chk(rdata, 32'h00000000);
   endtask : t_regs

   task automatic t_argb();
      wr_reg(cursor_pkg::POS_OFFSET, 32'h80050003);
      wr_reg(cursor_pkg::CTRL_OFFSET, 32'h00000027);
      wr_reg(cursor_pkg::BASE_OFFSET, 32'h12345000);
      // Active mode is already on, so the move waits for vblank
      @(posedge clk_sys iff vbl);
      wait_cyc(2);
      chk(fmt, cursor_pkg::FMT_ARGB);
      chk(sz, cursor_pkg::SIZE_LOG2_64);
      chk({vis, fen, phys}, 3'h6);
      chk(fbase, 39'h0012345000);
      chk({px, py}, {13'h0003, 13'h1FFB});
   endtask : t_argb

   task automatic t_inv();
      logic [7:0] av [3] = '{8'hFF, 8'h00, 8'h80};
      cursor_pkg::pixel_op_t ops [3] = '{cursor_pkg::PIX_OPAQUE, cursor_pkg::PIX_TRANSPARENT,
         cursor_pkg::PIX_INVERT};
      wr_reg(cursor_pkg::CTRL_OFFSET, 32'h00008007);
      @(posedge clk_sys iff vbl);
      wait_cyc(2);
      chk(fmt, cursor_pkg::FMT_ARGB);
      wr_reg(cursor_pkg::BASE_OFFSET, 32'h00100000);
      wait_cyc(2);
      chk(fmt, cursor_pkg::FMT_ARGB);
      @(posedge clk_sys iff vbl);
      wait_cyc(2);
      chk(fmt, cursor_pkg::FMT_AND_INVERT);
      chk({rot, pfe}, 2'h3);
      chk(fstart, 39'h0000103FFC);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         alpha <= av[i];
         wait_cyc(1);
         chk(pop, ops[i]);
      end
      @(posedge clk_sys);
      pcd <= 1'h1;
      wait_cyc(2);
      chk({vis, fen}, 2'h1);
      rd_reg(cursor_pkg::CTRL_OFFSET);
      chk(rdata, 32'h00008007);
      @(posedge clk_sys);
      pcd <= 1'h0;
   endtask : t_inv

   task automatic t_off();
      wr_reg(cursor_pkg::CTRL_OFFSET, 32'h00000000);
      wr_reg(cursor_pkg::BASE_OFFSET, 32'h00100000);
      @(posedge clk_sys iff vbl);
      wait_cyc(2);
      chk({fmt, fen}, {cursor_pkg::FMT_NONE, 1'h1});
      @(posedge clk_sys iff vbl);
      wait_cyc(1);
      chk(fen, 1'h0);
   endtask : t_off

   task automatic t_pipe();
      // Start just after vblank so no vblank falls inside the scenario
      @(posedge clk_sys iff vbl);
      wr_reg(cursor_pkg::CTRL_OFFSET, 32'h00000027);
      wr_reg(cursor_pkg::BASE_OFFSET, 32'h00200000);
      wait_cyc(2);
      chk({fmt, fen}, {cursor_pkg::FMT_ARGB, 1'h1});
      wr_reg(cursor_pkg::POS_OFFSET, 32'h00000010);
      wr_reg(cursor_pkg::BASE_OFFSET, 32'h00300000);
      @(posedge clk_sys);
      pen <= 1'h0;
      wait_cyc(2);
      chk(fbase, 39'h0000300000);
      chk({fen, px}, {1'h0, 13'h0010});
      wr_reg(cursor_pkg::POS_OFFSET, 32'h00200020);
      wr_reg(cursor_pkg::CTRL_OFFSET, 32'h08000004);
      wr_reg(cursor_pkg::POPUP_OFFSET, 32'hABCDE05A);
      wait_cyc(2);
      chk({fmt, phys, vis}, {cursor_pkg::FMT_IDX3, 2'h3});
      chk(fbase, 39'h5AABCDE000);
      wr_reg(cursor_pkg::CTRL_OFFSET, 32'h00000021);
      wr_reg(cursor_pkg::BASE_OFFSET, 32'h00300000);
      wait_cyc(2);
      chk({fmt, vis, pop}, {cursor_pkg::FMT_NONE, 1'h0, cursor_pkg::PIX_TRANSPARENT});
      @(posedge clk_sys);
      pen <= 1'h1;
      wait_cyc(2);
      chk(fen, 1'h0);
   endtask : t_pipe

   task automatic final_report();
      if (error_cnt == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1'h1;
      t_regs();
      t_argb();
      t_inv();
      t_off();
      t_pipe();
      final_report();
   end
endmodule : hw_cursor_plane_config_bench

// ### verification/pipe_model.sv
// Display pipe stand-in that issues a periodic vertical blank pulse
`timescale 1ns/1ps
module pipe_model (
   input wire logic clk_sys,
   input wire logic resetn,
   output logic vblank_start
);
   logic [4:0] cnt;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt <= 5'h00;
         vblank_start <= 1'h0;
      end else begin
         cnt <= cnt + 5'h01;
         vblank_start <= (cnt == 5'h1F);
      end
   end
endmodule : pipe_model
